// >>> shared/rtw_pkg.sv
// Purpose: Shared constants and types for the response timeout and wait extension block
// Assumes: 100 MHz system clock
// Notes:   Timing counts derive from the times in milliseconds
`default_nettype none
package rtw_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int FRAME_WAIT_MS    = 77;
   localparam int RESP_TIME_MS     = 55;
   localparam int WTX_DELAY_MS     = 2;
   localparam int NS_PER_MS        = 1000000;
   localparam int RESP_TIMEOUT_CYC = (RESP_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
   localparam int WTX_DELAY_CYC    = (WTX_DELAY_MS * NS_PER_MS) / CLK_PERIOD_NS;
   localparam int TIMER_W          = 23;

   // ----------------------------------------
   // Protocol values
   // ----------------------------------------
   localparam logic [3:0]  FRAME_WAIT_INT = 4'h8;
   localparam logic [15:0] SW_SUCCESS     = 16'h9000;
   localparam int          WAIT_EXTENSION_MULTIPLIER_W         = 6;

   // ----------------------------------------
   // General control register
   // ----------------------------------------
   localparam logic [15:0] GEN_CTRL_ADDR_LO = 16'hfffe;
   localparam logic [15:0] GEN_CTRL_ADDR_HI = 16'hffff;
   localparam logic [15:0] GEN_CTRL_RESET   = 16'h0000;
   localparam int BIT_SW_RESET    = 0;
   localparam int BIT_RF_ENABLE   = 1;
   localparam int BIT_INT_ENABLE  = 2;
   localparam int BIT_INT_HIGH    = 3;
   localparam int BIT_INT_DRIVE   = 4;
   localparam int BIT_BIP8        = 5;
   localparam int BIT_STANDBY_EN  = 6;
   localparam int BIT_AUTO_ACK    = 8;
   localparam logic [15:0] GEN_CTRL_WMASK = 16'h017e;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_HOST,
      ST_EXT_PENDING,
      ST_EXT_SENT
   } rtw_state_e;

endpackage
`default_nettype wire

// >>> shared/rtw_timer_if.sv
// Purpose: Control and status of the response timer
// Assumes: One controller and one timer on the same clock
// Notes:   Start has priority over stop
`timescale 1ns/1ps
`default_nettype none
interface rtw_timer_if #(
   parameter int W = 23
);
   logic         start;
   logic         stop;
   logic [W-1:0] limit;
   logic         expired;
   logic         running;

   modport ctrl (output start, output stop, output limit, input expired, input running);
   modport tmr  (input start, input stop, input limit, output expired, output running);
endinterface
`default_nettype wire

// >>> hw/rtw_resp_timer.sv
// Purpose: Down counter that pulses once when a loaded limit has elapsed
// Assumes: Limit is at least one cycle
// Notes:   Expired is a one-cycle pulse, limit cycles after start
`timescale 1ns/1ps
`default_nettype none
module rtw_resp_timer #(
   parameter int W = 23
) (
   input  wire logic   clk_sys,
   input  wire logic   reset_n,
   rtw_timer_if.tmr    tif
);
   logic [W-1:0] countReg;
   logic         runReg;
   logic         expReg;

   assign tif.running = runReg;
   assign tif.expired = expReg;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         countReg <= '0;
         runReg   <= 1'b0;
         expReg   <= 1'b0;
      end else begin
         expReg <= 1'b0;
         if (tif.start) begin
            countReg <= tif.limit;
            runReg   <= 1'b1;
         end else if (tif.stop) begin
            runReg <= 1'b0;
         end else if (runReg) begin
            if (countReg <= W'(1)) begin
               runReg <= 1'b0;
               expReg <= 1'b1;
            end else begin
               countReg <= countReg - W'(1);
            end
         end
      end
   end

   AST_TIMER_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tif.expired |=> !tif.expired)
      else $error("timer expiry lasted more than one cycle");
endmodule
`default_nettype wire

// >>> hw/rtw_resp_timeout_wtx.sv
// Purpose: Host response watchdog with wait time extension toward the reader
// Assumes: Reader front end and host logic share clk_sys; host bits arrive as plain inputs
// Notes:   Registers reached by byte address; one 16-bit control register
`timescale 1ns/1ps
`default_nettype none
module rtw_resp_timeout_wtx
   import rtw_pkg::*;
#(
   parameter int RESP_CYC = RESP_TIMEOUT_CYC,
   parameter int WTX_CYC  = WTX_DELAY_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic [15:0]       regAddr,
   input  wire logic              regWrEn,
   input  wire logic [7:0]        regWrData,
   output logic      [7:0]        regRdData,
   input  wire logic              cmdValid,
   input  wire logic              cmdNeedsHost,
   input  wire logic              cmdIsUpdate,
   input  wire logic              commActive,
   input  wire logic              hostDone,
   input  wire logic              hostIrqClear,
   input  wire logic              useCustomSw,
   input  wire logic [15:0]       customSw,
   input  wire logic [WAIT_EXTENSION_MULTIPLIER_W-1:0] extensionValue,
   output logic      [3:0]        frameWaitInteger,
   output logic                   respValid,
   output logic                   respIsWtx,
   output logic      [15:0]       respSw,
   output logic      [WAIT_EXTENSION_MULTIPLIER_W-1:0] respWtxm,
   output logic                   cmdIgnored,
   output logic                   linkReady,
   output logic                   extPendingN,
   output logic                   hostIrqOut,
   output logic                   hostIrqOe,
   output logic                   rfEnable,
   output logic                   bipEnable,
   output logic                   standby
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   rtw_state_e  stateReg;
   logic [15:0] ctrlReg;
   logic        irqFlagReg;
   logic        swReset;
   logic        busy;
   logic        accept;
   logic        autoAckNow;
   logic        doneNow;
   logic        toExt;
   logic        toSent;

   rtw_timer_if #(.W(TIMER_W)) tif ();

   rtw_resp_timer #(.W(TIMER_W)) uTimer (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .tif     (tif)
   );

   function automatic logic [7:0] ctrl_byte(input logic [15:0] addr, input logic [15:0] ctrl);
      logic [7:0] b;
      b = 8'h00;
      if (addr == GEN_CTRL_ADDR_LO) begin
         b = ctrl[7:0];
      end else if (addr == GEN_CTRL_ADDR_HI) begin
         b = ctrl[15:8];
      end
      return b;
   endfunction

   // ----------------------------------------
   // Event decode
   // ----------------------------------------
   assign busy       = (stateReg != ST_IDLE);
   assign accept     = cmdValid && !busy && cmdNeedsHost;
   assign autoAckNow = accept && cmdIsUpdate && ctrlReg[BIT_AUTO_ACK];
   assign doneNow    = hostDone && busy;
   assign toExt      = (stateReg == ST_WAIT_HOST) && tif.expired && !hostDone;
   assign toSent     = (stateReg == ST_EXT_PENDING) && tif.expired && !hostDone;
   assign swReset    = regWrEn && (regAddr == GEN_CTRL_ADDR_LO) && regWrData[BIT_SW_RESET];

   // ----------------------------------------
   // Timer control
   // ----------------------------------------
   always_comb begin
      tif.start = 1'b0;
      tif.stop  = 1'b0;
      tif.limit = TIMER_W'(RESP_CYC);
      if (swReset || doneNow) begin
         tif.stop = 1'b1;
      end else if (accept && !autoAckNow) begin
         tif.start = 1'b1;
      end else if (toExt) begin
         tif.start = 1'b1;
         tif.limit = TIMER_W'(WTX_CYC);
      end else if (toSent) begin
         tif.start = 1'b1;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stateReg <= ST_IDLE;
      end else if (swReset) begin
         stateReg <= ST_IDLE;
      end else begin
         case (stateReg)
            ST_IDLE: begin
               if (accept && !autoAckNow) begin
                  stateReg <= ST_WAIT_HOST;
               end
            end
            ST_WAIT_HOST: begin
               if (doneNow) begin
                  stateReg <= ST_IDLE;
               end else if (toExt) begin
                  stateReg <= ST_EXT_PENDING;
               end
            end
            ST_EXT_PENDING: begin
               if (doneNow) begin
                  stateReg <= ST_IDLE;
               end else if (toSent) begin
                  stateReg <= ST_EXT_SENT;
               end
            end
            ST_EXT_SENT: begin
               if (doneNow) begin
                  stateReg <= ST_IDLE;
               end
            end
            default: begin
               stateReg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Link pins
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         linkReady   <= 1'b1;
         extPendingN <= 1'b1;
      end else if (swReset || doneNow || toSent) begin
         linkReady   <= 1'b1;
         extPendingN <= 1'b1;
      end else if (toExt) begin
         linkReady   <= 1'b0;
         extPendingN <= 1'b0;
      end
   end

   // ----------------------------------------
   // Reader responses
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         respValid  <= 1'b0;
         respIsWtx  <= 1'b0;
         respSw     <= 16'h0000;
         respWtxm   <= '0;
         cmdIgnored <= 1'b0;
      end else begin
         respValid  <= 1'b0;
         cmdIgnored <= cmdValid && busy && !swReset;
         if (swReset) begin
            respValid <= 1'b0;
         end else if (doneNow) begin
            respValid <= 1'b1;
            respIsWtx <= 1'b0;
            respSw    <= useCustomSw ? customSw : SW_SUCCESS;
         end else if (toSent) begin
            respValid <= 1'b1;
            respIsWtx <= 1'b1;
            respWtxm  <= extensionValue;
         end else if (autoAckNow) begin
            respValid <= 1'b1;
            respIsWtx <= 1'b0;
            respSw    <= SW_SUCCESS;
         end
      end
   end

   // ----------------------------------------
   // Host interrupt flag, set wins over clear
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irqFlagReg <= 1'b0;
      end else if (accept) begin
         irqFlagReg <= 1'b1;
      end else if (hostIrqClear || swReset) begin
         irqFlagReg <= 1'b0;
      end
   end

   always_comb begin
      hostIrqOut = (irqFlagReg && ctrlReg[BIT_INT_ENABLE]) ~^ ctrlReg[BIT_INT_HIGH];
      hostIrqOe  = ctrlReg[BIT_INT_DRIVE] || (irqFlagReg && ctrlReg[BIT_INT_ENABLE]);
   end

   // ----------------------------------------
   // General control register
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrlReg <= GEN_CTRL_RESET;
      end else if (regWrEn) begin
         if (regAddr == GEN_CTRL_ADDR_LO) begin
            ctrlReg[7:0] <= regWrData & GEN_CTRL_WMASK[7:0];
         end else if (regAddr == GEN_CTRL_ADDR_HI) begin
            ctrlReg[15:8] <= regWrData & GEN_CTRL_WMASK[15:8];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= ctrl_byte(regAddr, ctrlReg);
      end
   end

   // ----------------------------------------
   // Static outputs and standby
   // ----------------------------------------
   assign frameWaitInteger = FRAME_WAIT_INT;
   assign rfEnable         = ctrlReg[BIT_RF_ENABLE];
   assign bipEnable        = ctrlReg[BIT_BIP8];
   assign standby          = ctrlReg[BIT_STANDBY_EN] && !rfEnable && !commActive && !busy;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_FWI_EIGHT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      frameWaitInteger == 4'h8)
      else $error("frame wait integer is not eight");

   AST_IRQ_ON_CMD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (accept && !swReset) |=> irqFlagReg && (busy || $past(autoAckNow)))
      else $error("host interrupt not raised for pending command");

   AST_TIMER_START: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (accept && !autoAckNow && !swReset) |=> tif.running && stateReg == ST_WAIT_HOST)
      else $error("response timer not started");

   AST_PINS_LOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (toExt && !swReset) |=> !linkReady && !extPendingN)
      else $error("pins not driven low on timeout");

   AST_EXT_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !extPendingN |-> stateReg == ST_EXT_PENDING)
      else $error("extension pin low outside extension");

   AST_WTX_MULT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (toSent && !swReset) |=> respValid && respIsWtx && respWtxm == $past(extensionValue))
      else $error("extension request wrong or missing");

   AST_PINS_HIGH: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (respValid && respIsWtx) |-> linkReady && extPendingN)
      else $error("pins not released after extension sent");

   AST_SECOND_EXPIRY: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (stateReg == ST_EXT_SENT && tif.expired && !hostDone && !swReset)
      |=> !respValid && extPendingN && stateReg == ST_EXT_SENT)
      else $error("action taken on later expiry");

   AST_BUSY_SILENT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cmdValid && busy && !hostDone && !tif.expired && !swReset) |=> !respValid && cmdIgnored)
      else $error("reply sent while command pending");

   AST_LITTLE_END: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $past(regAddr) == GEN_CTRL_ADDR_HI |-> regRdData == $past(ctrlReg[15:8]))
      else $error("high byte not at odd address");

   AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ctrlReg[15:9] == 7'h00 && ctrlReg[7] == 1'b0)
      else $error("reserved control bits set");

   AST_AUTO_ACK: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (autoAckNow && !swReset) |=> respValid && !respIsWtx && respSw == SW_SUCCESS && !busy)
      else $error("update not acknowledged at once");

   AST_STANDBY: assert property (@(posedge clk_sys) disable iff (!reset_n)
      standby |-> !rfEnable && !commActive && stateReg == ST_IDLE)
      else $error("standby entered while active");

   AST_DEFAULT_SW: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (doneNow && !useCustomSw && !swReset) |=> respValid && respSw == SW_SUCCESS)
      else $error("default status word wrong");

   AST_DONE_CANCEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (doneNow && !swReset) |=> !tif.running && extPendingN && !respIsWtx && stateReg == ST_IDLE)
      else $error("host done did not cancel pending work");

   COV_EXTENSION: cover property (@(posedge clk_sys) disable iff (!reset_n)
      respValid && respIsWtx);
   COV_FAST_HOST: cover property (@(posedge clk_sys) disable iff (!reset_n)
      doneNow && stateReg == ST_WAIT_HOST);
   COV_DONE_AFTER_EXT: cover property (@(posedge clk_sys) disable iff (!reset_n)
      doneNow && stateReg == ST_EXT_SENT);
   COV_AUTO_ACK: cover property (@(posedge clk_sys) disable iff (!reset_n)
      autoAckNow);

endmodule
`default_nettype wire

// >>> verification/rtw_host_model.sv
// Purpose: Host controller model that services the device interrupt
// Assumes: Interrupt wire level is resolved by the bench, pulled up when released
// Notes:   Clears the flag after a set delay, then signals done one cycle later
`timescale 1ns/1ps
`default_nettype none
module rtw_host_model (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        irqWire,
   input  wire logic        irqActiveHigh,
   input  wire logic        serviceEn,
   input  wire logic [15:0] delayCyc,
   output logic             hostIrqClear,
   output logic             hostDone
);
   logic [15:0] waitCnt_reg;

   // ----------------------------------------
   // Service sequence
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         waitCnt_reg  <= 16'h0000;
         hostIrqClear <= 1'b0;
         hostDone     <= 1'b0;
      end else begin
         hostIrqClear <= 1'b0;
         hostDone     <= hostIrqClear;
         if (serviceEn && irqWire == irqActiveHigh && !hostIrqClear && !hostDone) begin
            waitCnt_reg <= waitCnt_reg + 16'h0001;
            if (waitCnt_reg == delayCyc) begin
               hostIrqClear <= 1'b1;
               waitCnt_reg  <= 16'h0000;
            end
         end else begin
            waitCnt_reg <= 16'h0000;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/test_rtw_resp_timeout_wtx.sv
// Purpose: Self-checking bench for the response watchdog and wait extension block
// Assumes: Shortened timer counts; host serviced by the host model
// Notes:   Interrupt pin is active low, open drain with a pull-up
`timescale 1ns/1ps
`default_nettype none
module test_rtw_resp_timeout_wtx
   import rtw_pkg::*;
;
   localparam int RC = 40;
   localparam int WC = 10;
   logic              clk_sys, reset_n, regWrEn, cmdValid, cmdNeedsHost, cmdIsUpdate;
   logic              commActive, hostDone, hostIrqClear, useCustomSw, serviceEn;
   logic              respValid, respIsWtx, cmdIgnored, linkReady, extPendingN;
   logic              hostIrqOut, hostIrqOe, rfEnable, bipEnable, standby, irqWire, bad;
   logic [15:0]       regAddr, customSw, respSw, delayCyc;
   logic [7:0]        regWrData, regRdData;
   logic [WAIT_EXTENSION_MULTIPLIER_W-1:0] extensionValue, respWtxm;
   logic [3:0]        frameWaitInteger;
   int                failures, cmp_count, cycleCnt;

   assign irqWire = hostIrqOe ? hostIrqOut : 1'b1;

   rtw_resp_timeout_wtx #(.RESP_CYC(RC), .WTX_CYC(WC)) dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdData(regRdData), .cmdValid(cmdValid),
      .cmdNeedsHost(cmdNeedsHost), .cmdIsUpdate(cmdIsUpdate), .commActive(commActive),
      .hostDone(hostDone), .hostIrqClear(hostIrqClear), .useCustomSw(useCustomSw),
      .customSw(customSw), .extensionValue(extensionValue), .frameWaitInteger(frameWaitInteger),
      .respValid(respValid), .respIsWtx(respIsWtx), .respSw(respSw), .respWtxm(respWtxm),
      .cmdIgnored(cmdIgnored), .linkReady(linkReady), .extPendingN(extPendingN),
      .hostIrqOut(hostIrqOut), .hostIrqOe(hostIrqOe), .rfEnable(rfEnable),
      .bipEnable(bipEnable), .standby(standby));

   rtw_host_model host (
      .clk_sys(clk_sys), .reset_n(reset_n), .irqWire(irqWire), .irqActiveHigh(1'b0),
      .serviceEn(serviceEn), .delayCyc(delayCyc), .hostIrqClear(hostIrqClear),
      .hostDone(hostDone));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycleCnt++;
      if (cycleCnt == 5000) begin
         failures++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic regWrite(input logic [15:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      regAddr   <= addr;
      regWrEn   <= 1'b1;
      regWrData <= data;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
      #1;
   endtask

   task automatic regRead(input logic [15:0] addr, input logic [7:0] exp);
      @(posedge clk_sys);
      regAddr <= addr;
      @(posedge clk_sys);
      #1;
      check(16'(regRdData), 16'(exp));
   endtask

   task automatic sendCmd(input logic upd);
      @(posedge clk_sys);
      cmdValid     <= 1'b1;
      cmdNeedsHost <= 1'b1;
      cmdIsUpdate  <= upd;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
      #1;
   endtask

   function automatic logic hit(input int sel);
      case (sel)
         0: return respValid === 1'b1;
         1: return extPendingN === 1'b0;
         default: return cmdIgnored === 1'b1;
      endcase
   endfunction

   // Event must appear between lo and hi cycles from now
   task automatic waitFor(input int sel, input int lo, input int hi);
      int n;
      n = 0;
      while (!hit(sel) && n <= hi) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check(16'(n >= lo && n <= hi), 16'h0001);
   endtask

   // No response and both pins high for the whole span
   task automatic quietFor(input int cycles);
      bad = 1'b0;
      repeat (cycles) begin
         @(posedge clk_sys);
         #1;
         if (respValid !== 1'b0 || extPendingN !== 1'b1 || linkReady !== 1'b1)
            bad = 1'b1;
      end
      check(16'(bad), 16'h0000);
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      reset_n        = 1'b0;
      regAddr        = 16'h0000;
      regWrEn        = 1'b0;
      regWrData      = 8'h00;
      cmdValid       = 1'b0;
      cmdNeedsHost   = 1'b0;
      cmdIsUpdate    = 1'b0;
      commActive     = 1'b0;
      useCustomSw    = 1'b0;
      customSw       = 16'h6a82;
      extensionValue = 6'h2a;
      serviceEn      = 1'b1;
      delayCyc       = 16'h0005;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1;
      check(16'({linkReady, extPendingN, hostIrqOe}), 16'h0006);
      check(16'(frameWaitInteger), 16'h0008);
      regRead(16'hfffe, 8'h00);
      regRead(16'hffff, 8'h00);
      $display("test reset done");

      regWrite(16'hfffe, 8'hff);
      regWrite(16'hffff, 8'hff);
      regRead(16'hfffe, 8'h7e);
      regRead(16'hffff, 8'h01);
      regRead(16'h0010, 8'h00);
      check(16'({rfEnable, bipEnable}), 16'h0003);
      regWrite(16'hffff, 8'h00);
      regWrite(16'hfffe, 8'h40);
      check(16'(standby), 16'h0001);
      @(posedge clk_sys);
      commActive <= 1'b1;
      @(posedge clk_sys);
      #1;
      check(16'(standby), 16'h0000);
      commActive <= 1'b0;
      regWrite(16'hfffe, 8'h42);
      check(16'(standby), 16'h0000);
      regWrite(16'hfffe, 8'h04);
      $display("test registers done");

      for (int i = 0; i < 2; i++) begin
         useCustomSw <= i[0];
         sendCmd(1'b0);
         @(posedge clk_sys);
         #1;
         check(16'(irqWire), 16'h0000);
         waitFor(0, 0, 30);
         check(respSw, i == 1 ? 16'h6a82 : 16'h9000);
         check(16'(respIsWtx), 16'h0000);
      end
      useCustomSw <= 1'b0;
      $display("test service done");

      sendCmd(1'b0);
      sendCmd(1'b0);
      waitFor(2, 0, 2);
      waitFor(0, 0, 30);
      quietFor(15);
      $display("test busy done");

      delayCyc <= 16'(3 * RC);
      sendCmd(1'b0);
      waitFor(1, RC - 1, RC + 3);
      check(16'(linkReady), 16'h0000);
      repeat (WC / 2) @(posedge clk_sys);
      #1;
      check(16'({linkReady, extPendingN}), 16'h0000);
      waitFor(0, 1, WC / 2 + 4);
      check(16'({respIsWtx, respWtxm}), 16'h006a);
      quietFor(RC + 5);
      waitFor(0, 0, 3 * RC);
      check(respSw, 16'h9000);
      check(16'(respIsWtx), 16'h0000);
      $display("test timeout done");

      delayCyc <= 16'(RC + 2);
      sendCmd(1'b0);
      waitFor(1, RC - 1, RC + 3);
      waitFor(0, 0, WC + 4);
      check(16'(respIsWtx), 16'h0000);
      quietFor(RC + WC);
      $display("test cancel done");

      delayCyc <= 16'(3 * RC);
      sendCmd(1'b0);
      waitFor(1, RC - 1, RC + 3);
      regWrite(16'hfffe, 8'h05);
      check(16'({linkReady, extPendingN, irqWire}), 16'h0007);
      quietFor(RC + WC + 5);
      $display("test soft reset done");

      delayCyc <= 16'h0005;
      regWrite(16'hffff, 8'h01);
      for (int i = 0; i < 2; i++) begin
         sendCmd(1'b1);
         waitFor(0, 0, 2);
         check(respSw, 16'h9000);
         check(16'(respIsWtx), 16'h0000);
      end
      check(16'(irqWire), 16'h0000);
      quietFor(20);
      $display("test auto ack done");
      print_verdict();
   end
endmodule
`default_nettype wire
